// ---- core/flash_wake_defs.svh ----
// constants for the wake, identify and parameter-space read logic
`ifndef FLASH_WAKE_DEFS_SVH
`define FLASH_WAKE_DEFS_SVH

`define OP_WAKE_ID 8'hAB
`define OP_PARAM_READ 8'h5A
`define ID_DUMMY_BYTES 3
`define PARAM_ADDR_BYTES 3
`define PARAM_DUMMY_CLKS 8
`define PARAM_HDR_BASE 24'h00_0000
`define PARAM_HDR_LEN 8
`define PARAM_TBL_BASE 24'h00_0300
`define PARAM_TBL_LEN 16
`define PARAM_4B_BASE 24'h00_0340
`define PARAM_4B_LEN 16
`define PARAM_UNDEF 8'hFF
`define SIG_BYTE0 8'h53
`define SIG_BYTE1 8'h46
`define SIG_BYTE2 8'h44
`define SIG_BYTE3 8'h50
`define HDR_MINOR_REV 8'h06
`define HDR_MAJOR_REV 8'h01
`define HDR_NUM_PARAMS 8'h01
`define CLK_PERIOD_PS 5000
`define WAKE_RECOVERY_NS 3000
`define WAKE_RECOVERY_CYC ((`WAKE_RECOVERY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- core/flash_wake_pkg.sv ----
// types for the wake, identify and parameter-space read logic
`default_nettype none
package flash_wake_pkg;
	typedef enum logic [3:0] {
		DEV_CMD = 4'b0001,
		DEV_ADDR = 4'b0010,
		DEV_DUMMY = 4'b0100,
		DEV_OUT = 4'b1000
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b001,
		HOST_XFER = 3'b010,
		HOST_GAP = 3'b100
	} host_state_t;
	typedef enum logic [1:0] {
		CMD_WAKE = 2'h0,
		CMD_IDENTIFY = 2'h1,
		CMD_PARAM_READ = 2'h2
	} host_cmd_t;
endpackage
`default_nettype wire

// ---- core/spi_link_if.sv ----
// serial link between the host controller and the memory
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_out;
	logic [3:0] host_oe;
	logic [3:0] dev_out;
	logic [3:0] dev_oe;
	logic [3:0] io;

	// resolved data lines; an undriven line reads high (pull-up)
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			io[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sclk, output host_out, output host_oe, input io);
	modport device (input cs_n, input sclk, input io, output dev_out, output dev_oe);
endinterface
`default_nettype wire

// ---- core/flash_wake_dev.sv ----
// memory end: wake from deep sleep, identifier readout, parameter-space reads
// Function
// [RULE1] opcode ABh alone wakes from deep sleep
// [RULE2] no command accepted during wake recovery time
// [RULE3] ABh plus three dummy bytes returns identifier
// [RULE4] identifier shifted on falling edge, msb first
// [RULE5] clocking past identifier gives undefined data; the code sends DEV_ID again for every further byte
// [RULE6] select high ends command, output released
// [RULE7] ABh ignored entirely while busy
// [RULE8] quad mode: four bits per clock both ways
// [RULE9] opcode 5Ah reads separate parameter space
// [RULE10] header at 0000h, basic table at 0300h
// [RULE11] order: header, basic table, four-byte table
// [RULE12] parameter space is read-only
// [RULE13] deep sleep accepts only the wake opcode
// [RULE14] header byte 00h reads ASCII S
// [RULE15] param read: opcode, 24-bit address, 8 dummies
`timescale 1ns/1ps
`default_nettype none
`include "flash_wake_defs.svh"
module flash_wake_dev
	import flash_wake_pkg::*;
#(
	parameter logic [7:0] DEV_ID = 8'h5C, // arbitrary value
	parameter logic [8*`PARAM_TBL_LEN-1:0] BASIC_TBL = '1,
	parameter logic [8*`PARAM_4B_LEN-1:0] ADDR4_TBL = '1
)
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// serial link
	spi_link_if.device link,
	// device side status and control
	input wire logic i_busy,
	input wire logic i_quad_mode,
	input wire logic i_sleep_req,
	output logic o_deep_sleep,
	output logic o_recovering,
	output logic o_cmd_ignored
);
	dev_state_t st_r, st_nxt;
	logic sclk_q_r, sclk_q_nxt;
	logic cs_q_r, cs_q_nxt;
	logic [7:0] in_sh_r, in_sh_nxt;
	logic [3:0] in_cnt_r, in_cnt_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic [1:0] byte_cnt_r, byte_cnt_nxt;
	logic [4:0] dummy_r, dummy_nxt;
	logic id_mode_r, id_mode_nxt;
	logic [7:0] out_sh_r, out_sh_nxt;
	logic [3:0] out_cnt_r, out_cnt_nxt;
	logic [3:0] dout_r, dout_nxt;
	logic asleep_r, asleep_nxt;
	logic [15:0] rec_r, rec_nxt;
	logic wake_seen_r, wake_seen_nxt;
	logic ignored_r, ignored_nxt;
	logic rise, fall, cs_rise;
	logic [3:0] step;
	logic [7:0] shifted;
	logic [7:0] fetched;

	// constant contents; nothing here is writable from the link
	function automatic logic [7:0] param_byte(input logic [23:0] a); // RULE12
		logic [23:0] off;
		off = '0;
		if (a < `PARAM_HDR_BASE + `PARAM_HDR_LEN) // RULE10
		begin
			case (a[2:0])
				3'h0: param_byte = `SIG_BYTE0; // RULE14
				3'h1: param_byte = `SIG_BYTE1;
				3'h2: param_byte = `SIG_BYTE2;
				3'h3: param_byte = `SIG_BYTE3;
				3'h4: param_byte = `HDR_MINOR_REV;
				3'h5: param_byte = `HDR_MAJOR_REV;
				3'h6: param_byte = `HDR_NUM_PARAMS;
				default: param_byte = `PARAM_UNDEF;
			endcase
		end
		else if (a >= `PARAM_TBL_BASE && a < `PARAM_TBL_BASE + `PARAM_TBL_LEN) // RULE10
		begin
			off = a - `PARAM_TBL_BASE;
			param_byte = BASIC_TBL[off[3:0]*8 +: 8]; // RULE11
		end
		else if (a >= `PARAM_4B_BASE && a < `PARAM_4B_BASE + `PARAM_4B_LEN)
		begin
			off = a - `PARAM_4B_BASE;
			param_byte = ADDR4_TBL[off[3:0]*8 +: 8]; // RULE11
		end
		else
		begin
			param_byte = `PARAM_UNDEF;
		end
	endfunction

	assign rise = link.sclk && !sclk_q_r && !link.cs_n;
	assign fall = !link.sclk && sclk_q_r && !link.cs_n;
	assign cs_rise = link.cs_n && !cs_q_r;
	assign step = i_quad_mode ? 4'h4 : 4'h1; // RULE8
	assign shifted = i_quad_mode ? {in_sh_r[3:0], link.io} : {in_sh_r[6:0], link.io[0]};
	assign fetched = id_mode_r ? DEV_ID : param_byte(addr_r); // RULE5

	always_comb
	begin
		st_nxt = st_r;
		sclk_q_nxt = link.sclk;
		cs_q_nxt = link.cs_n;
		in_sh_nxt = in_sh_r;
		in_cnt_nxt = in_cnt_r;
		addr_nxt = addr_r;
		byte_cnt_nxt = byte_cnt_r;
		dummy_nxt = dummy_r;
		id_mode_nxt = id_mode_r;
		out_sh_nxt = out_sh_r;
		out_cnt_nxt = out_cnt_r;
		dout_nxt = dout_r;
		asleep_nxt = asleep_r;
		rec_nxt = rec_r;
		wake_seen_nxt = wake_seen_r;
		ignored_nxt = 1'b0;
		if (rec_r != 16'h0000)
		begin
			rec_nxt = rec_r - 16'h0001; // RULE2
		end
		if (i_sleep_req && !i_busy)
		begin
			asleep_nxt = 1'b1;
		end
		if (link.cs_n)
		begin
			st_nxt = DEV_CMD; // RULE6
			in_cnt_nxt = 4'h0;
			out_cnt_nxt = 4'h0;
			wake_seen_nxt = 1'b0;
			if (cs_rise && wake_seen_r && asleep_r)
			begin
				asleep_nxt = 1'b0; // RULE1
				rec_nxt = 16'(`WAKE_RECOVERY_CYC); // RULE2
			end
		end
		else if (rise)
		begin
			case (st_r)
				DEV_CMD:
				begin
					in_sh_nxt = shifted;
					in_cnt_nxt = in_cnt_r + step;
					if (in_cnt_r + step == 4'h8)
					begin
						in_cnt_nxt = 4'h0;
						if (shifted == `OP_WAKE_ID && !i_busy && rec_r == 16'h0000) // RULE7
						begin
							wake_seen_nxt = 1'b1; // RULE1
							id_mode_nxt = 1'b1;
							st_nxt = DEV_DUMMY; // RULE3
							dummy_nxt = 5'((`ID_DUMMY_BYTES * 8) / step);
						end
						else if (shifted == `OP_PARAM_READ && !asleep_r && rec_r == 16'h0000) // RULE9 RULE13
						begin
							id_mode_nxt = 1'b0;
							byte_cnt_nxt = 2'h0;
							st_nxt = DEV_ADDR;
						end
						else
						begin
							st_nxt = DEV_ADDR;
							byte_cnt_nxt = 2'h3;
							ignored_nxt = 1'b1; // RULE13
						end
					end
				end
				DEV_ADDR:
				begin
					// byte_cnt 3 marks an ignored command that waits for select high
					if (byte_cnt_r != 2'h3)
					begin
						in_sh_nxt = shifted;
						in_cnt_nxt = in_cnt_r + step;
						if (in_cnt_r + step == 4'h8)
						begin
							in_cnt_nxt = 4'h0;
							addr_nxt = {addr_r[15:0], shifted}; // RULE15
							if (byte_cnt_r == 2'(`PARAM_ADDR_BYTES - 1))
							begin
								st_nxt = DEV_DUMMY;
								dummy_nxt = 5'(`PARAM_DUMMY_CLKS); // RULE15
							end
							else
							begin
								byte_cnt_nxt = byte_cnt_r + 2'h1;
							end
						end
					end
				end
				DEV_DUMMY:
				begin
					if (dummy_r == 5'h01)
					begin
						st_nxt = DEV_OUT;
					end
					dummy_nxt = dummy_r - 5'h01;
				end
				default:
				begin
					st_nxt = st_r;
				end
			endcase
		end
		else if (fall && st_r == DEV_OUT) // RULE4
		begin
			if (out_cnt_r == 4'h0)
			begin
				if (!id_mode_r)
				begin
					addr_nxt = addr_r + 24'h00_0001; // RULE15
				end
				dout_nxt = i_quad_mode ? fetched[7:4] : {2'b00, fetched[7], 1'b0};
				out_sh_nxt = i_quad_mode ? {fetched[3:0], 4'h0} : {fetched[6:0], 1'b0};
				out_cnt_nxt = 4'h8 - step;
			end
			else
			begin
				dout_nxt = i_quad_mode ? out_sh_r[7:4] : {2'b00, out_sh_r[7], 1'b0}; // RULE8
				out_sh_nxt = i_quad_mode ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0};
				out_cnt_nxt = out_cnt_r - step;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_r <= DEV_CMD;
			sclk_q_r <= 1'b0;
			cs_q_r <= 1'b1;
			in_sh_r <= 8'h00;
			in_cnt_r <= 4'h0;
			addr_r <= 24'h00_0000;
			byte_cnt_r <= 2'h0;
			dummy_r <= 5'h00;
			id_mode_r <= 1'b0;
			out_sh_r <= 8'h00;
			out_cnt_r <= 4'h0;
			dout_r <= 4'h0;
			asleep_r <= 1'b0;
			rec_r <= 16'h0000;
			wake_seen_r <= 1'b0;
			ignored_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			sclk_q_r <= sclk_q_nxt;
			cs_q_r <= cs_q_nxt;
			in_sh_r <= in_sh_nxt;
			in_cnt_r <= in_cnt_nxt;
			addr_r <= addr_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			dummy_r <= dummy_nxt;
			id_mode_r <= id_mode_nxt;
			out_sh_r <= out_sh_nxt;
			out_cnt_r <= out_cnt_nxt;
			dout_r <= dout_nxt;
			asleep_r <= asleep_nxt;
			rec_r <= rec_nxt;
			wake_seen_r <= wake_seen_nxt;
			ignored_r <= ignored_nxt;
		end
	end

	// drive only in the data phase with select low
	assign link.dev_oe = (st_r == DEV_OUT && !link.cs_n) ? (i_quad_mode ? 4'hF : 4'h2) : 4'h0; // RULE6
	assign link.dev_out = dout_r;
	assign o_deep_sleep = asleep_r;
	assign o_recovering = rec_r != 16'h0000;
	assign o_cmd_ignored = ignored_r;
endmodule
`default_nettype wire

// ---- core/flash_wake_host.sv ----
// host end: issues wake, identify and parameter-space read transfers
`timescale 1ns/1ps
`default_nettype none
`include "flash_wake_defs.svh"
module flash_wake_host
	import flash_wake_pkg::*;
#(
	parameter int HALF_DIV = 2
)
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// serial link
	spi_link_if.host link,
	// request
	input wire logic i_start,
	input wire host_cmd_t i_cmd,
	input wire logic i_quad,
	input wire logic [23:0] i_addr,
	input wire logic [7:0] i_rx_len,
	output logic o_ready,
	// answer
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_done
);
	host_state_t st_r, st_nxt;
	logic [7:0] div_r, div_nxt;
	logic sclk_r, sclk_nxt;
	logic cs_n_r, cs_n_nxt;
	logic quad_r, quad_nxt;
	logic [31:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] hout_r, hout_nxt;
	logic [3:0] hoe_r, hoe_nxt;
	logic [11:0] idx_r, idx_nxt;
	logic [11:0] tx_clks_r, tx_clks_nxt;
	logic [11:0] rx_start_r, rx_start_nxt;
	logic [11:0] total_r, total_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt;
	logic [7:0] rx_data_r, rx_data_nxt;
	logic rx_valid_r, rx_valid_nxt;
	logic done_r, done_nxt;
	logic [15:0] gap_r, gap_nxt;
	logic wake_r, wake_nxt;
	logic [11:0] step;
	logic [11:0] dummy;
	logic [31:0] frame;

	assign step = i_quad ? 12'h004 : 12'h001;
	assign frame = (i_cmd == CMD_PARAM_READ) ? {`OP_PARAM_READ, i_addr} : {`OP_WAKE_ID, 24'h00_0000};
	assign dummy = (i_cmd == CMD_PARAM_READ) ? 12'(`PARAM_DUMMY_CLKS) :
		(i_cmd == CMD_IDENTIFY) ? 12'((`ID_DUMMY_BYTES * 8) / step) : 12'h000; // RULE3 RULE15

	always_comb
	begin
		st_nxt = st_r;
		div_nxt = div_r;
		sclk_nxt = sclk_r;
		cs_n_nxt = cs_n_r;
		quad_nxt = quad_r;
		tx_sh_nxt = tx_sh_r;
		hout_nxt = hout_r;
		hoe_nxt = hoe_r;
		idx_nxt = idx_r;
		tx_clks_nxt = tx_clks_r;
		rx_start_nxt = rx_start_r;
		total_nxt = total_r;
		rx_sh_nxt = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_data_nxt = rx_data_r;
		rx_valid_nxt = 1'b0;
		done_nxt = 1'b0;
		gap_nxt = gap_r;
		wake_nxt = wake_r;
		case (st_r)
			HOST_IDLE:
			begin
				if (i_start)
				begin
					quad_nxt = i_quad;
					wake_nxt = i_cmd != CMD_PARAM_READ;
					tx_clks_nxt = ((i_cmd == CMD_PARAM_READ) ? 12'h020 : 12'h008) / step;
					rx_start_nxt = tx_clks_nxt + dummy;
					total_nxt = rx_start_nxt + ((i_cmd == CMD_WAKE) ? 12'h000 :
						12'({i_rx_len, 3'b000} / step));
					hout_nxt = i_quad ? frame[31:28] : {3'b000, frame[31]};
					hoe_nxt = i_quad ? 4'hF : 4'h1;
					tx_sh_nxt = i_quad ? {frame[27:0], 4'h0} : {frame[30:0], 1'b0};
					cs_n_nxt = 1'b0;
					div_nxt = 8'h00;
					idx_nxt = 12'h000;
					rx_cnt_nxt = 4'h0;
					st_nxt = HOST_XFER;
				end
			end
			HOST_XFER:
			begin
				div_nxt = div_r + 8'h01;
				if (div_r == 8'(HALF_DIV - 1))
				begin
					div_nxt = 8'h00;
					if (!sclk_r)
					begin
						sclk_nxt = 1'b1;
						idx_nxt = idx_r + 12'h001;
						if (idx_r >= rx_start_r)
						begin
							rx_sh_nxt = quad_r ? {rx_sh_r[3:0], link.io} : {rx_sh_r[6:0], link.io[1]};
							rx_cnt_nxt = rx_cnt_r + (quad_r ? 4'h4 : 4'h1);
							if (rx_cnt_nxt == 4'h8)
							begin
								rx_cnt_nxt = 4'h0;
								rx_data_nxt = rx_sh_nxt;
								rx_valid_nxt = 1'b1;
							end
						end
					end
					else
					begin
						sclk_nxt = 1'b0;
						if (idx_r == total_r)
						begin
							cs_n_nxt = 1'b1; // RULE6
							hoe_nxt = 4'h0;
							gap_nxt = wake_r ? 16'(`WAKE_RECOVERY_CYC) : 16'h0001; // RULE2
							st_nxt = HOST_GAP;
						end
						else if (idx_r < tx_clks_r)
						begin
							hout_nxt = quad_r ? tx_sh_r[31:28] : {3'b000, tx_sh_r[31]}; // RULE8
							tx_sh_nxt = quad_r ? {tx_sh_r[27:0], 4'h0} : {tx_sh_r[30:0], 1'b0};
						end
						else
						begin
							hoe_nxt = 4'h0;
						end
					end
				end
			end
			default:
			begin
				gap_nxt = gap_r - 16'h0001;
				if (gap_r == 16'h0001)
				begin
					done_nxt = 1'b1;
					st_nxt = HOST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_r <= HOST_IDLE;
			div_r <= 8'h00;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			quad_r <= 1'b0;
			tx_sh_r <= 32'h0000_0000;
			hout_r <= 4'h0;
			hoe_r <= 4'h0;
			idx_r <= 12'h000;
			tx_clks_r <= 12'h000;
			rx_start_r <= 12'h000;
			total_r <= 12'h000;
			rx_sh_r <= 8'h00;
			rx_cnt_r <= 4'h0;
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			done_r <= 1'b0;
			gap_r <= 16'h0000;
			wake_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			sclk_r <= sclk_nxt;
			cs_n_r <= cs_n_nxt;
			quad_r <= quad_nxt;
			tx_sh_r <= tx_sh_nxt;
			hout_r <= hout_nxt;
			hoe_r <= hoe_nxt;
			idx_r <= idx_nxt;
			tx_clks_r <= tx_clks_nxt;
			rx_start_r <= rx_start_nxt;
			total_r <= total_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_data_r <= rx_data_nxt;
			rx_valid_r <= rx_valid_nxt;
			done_r <= done_nxt;
			gap_r <= gap_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign link.cs_n = cs_n_r;
	assign link.sclk = sclk_r;
	assign link.host_out = hout_r;
	assign link.host_oe = hoe_r;
	assign o_ready = st_r == HOST_IDLE;
	assign o_rx_data = rx_data_r;
	assign o_rx_valid = rx_valid_r;
	assign o_done = done_r;
endmodule
`default_nettype wire

// ---- tb/flash_wake_sva.sv ----
// link and status checks for the wake, identify and parameter-read pair
`timescale 1ns/1ps
`default_nettype none
module flash_wake_sva
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// link and device status
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe,
	input wire logic i_busy,
	input wire logic o_deep_sleep,
	input wire logic o_recovering,
	input wire logic o_cmd_ignored
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_sclk_fell;
		$past(sclk, 2) && !$past(sclk);
	endsequence
	sequence s_recover_hold;
		o_recovering [*8];
	endsequence
	sequence s_recover_end;
		##[598:598] o_recovering ##[1:3] !o_recovering;
	endsequence

	a_release_on_deselect: assert property (cs_n |-> dev_oe == 4'h0)
		else $error("device drives while deselected");
	a_sclk_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("serial clock runs outside a frame");
	a_shift_on_fall: assert property (!cs_n && !$past(cs_n) && dev_oe != 4'h0
		&& $past(dev_oe) != 4'h0 && $changed(dev_out) |-> s_sclk_fell)
		else $error("output data changed away from a falling clock");
	a_busy_keeps_sleep: assert property (o_deep_sleep && i_busy && $past(i_busy)
		|=> o_deep_sleep)
		else $error("woke while busy");
	a_wake_recovers: assert property ($fell(o_deep_sleep) |-> ##[0:300] o_recovering)
		else $error("no recovery after wake");
	a_recover_hold: assert property ($rose(o_recovering) |-> s_recover_hold)
		else $error("recovery cut short");
	a_recover_length: assert property ($rose(o_recovering) |-> s_recover_end)
		else $error("recovery length wrong");
	a_quiet_recovery: assert property (o_recovering |-> cs_n && dev_oe == 4'h0)
		else $error("link active during recovery");
	a_ignored_in_frame: assert property (o_cmd_ignored |-> !$past(cs_n))
		else $error("ignore pulse outside a frame");
	a_ignored_silent: assert property (o_cmd_ignored |-> ##1 (dev_oe == 4'h0) [*8])
		else $error("device drives after refusing");
endmodule
`default_nettype wire

// ---- tb/power_down_wake_id_params_read_tb.sv ----
// bench for the host and memory ends joined by the serial link
`timescale 1ns/1ps
`default_nettype none
`include "flash_wake_defs.svh"
module power_down_wake_id_params_read_tb;
	import flash_wake_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h96; // arbitrary value
	localparam logic [127:0] BASIC = 128'hBFBE_BDBC_BBBA_B9B8_B7B6_B5B4_B3B2_B1B0;
	localparam logic [127:0] ADDR4 = 128'hCFCE_CDCC_CBCA_C9C8_C7C6_C5C4_C3C2_C1C0;
	logic i_core_clk, i_resetn, i_busy, i_quad_mode, i_sleep_req, i_start, i_quad;
	host_cmd_t i_cmd;
	logic [23:0] i_addr;
	logic [7:0] i_rx_len, o_rx_data;
	logic o_ready, o_rx_valid, o_done, o_deep_sleep, o_recovering, o_cmd_ignored;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000_ecba;
	int error_cnt = 0;
	int compares = 0;
	int ign_cnt = 0;
	int base;

	spi_link_if link();
	flash_wake_host flash_wake_host_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.link(link), .i_start(i_start), .i_cmd(i_cmd), .i_quad(i_quad), .i_addr(i_addr),
		.i_rx_len(i_rx_len), .o_ready(o_ready), .o_rx_data(o_rx_data),
		.o_rx_valid(o_rx_valid), .o_done(o_done));
	flash_wake_dev #(.DEV_ID(ID_VAL), .BASIC_TBL(BASIC), .ADDR4_TBL(ADDR4)) flash_wake_dev_i (
		.i_core_clk(i_core_clk), .i_resetn(i_resetn), .link(link), .i_busy(i_busy),
		.i_quad_mode(i_quad_mode), .i_sleep_req(i_sleep_req), .o_deep_sleep(o_deep_sleep),
		.o_recovering(o_recovering), .o_cmd_ignored(o_cmd_ignored));
	flash_wake_sva flash_wake_sva_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.cs_n(link.cs_n), .sclk(link.sclk), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
		.i_busy(i_busy), .o_deep_sleep(o_deep_sleep), .o_recovering(o_recovering),
		.o_cmd_ignored(o_cmd_ignored));

	initial
	begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] exp_byte(host_cmd_t c, logic [23:0] a);
		logic [7:0] hdr[8];
		hdr = '{`SIG_BYTE0, `SIG_BYTE1, `SIG_BYTE2, `SIG_BYTE3,
			`HDR_MINOR_REV, `HDR_MAJOR_REV, `HDR_NUM_PARAMS, 8'hFF};
		if (c == CMD_IDENTIFY)
			return ID_VAL;
		if (a < 24'h00_0008)
			return hdr[a[2:0]];
		if (a >= 24'h00_0300 && a < 24'h00_0310)
			return BASIC[8*a[3:0] +: 8];
		if (a >= 24'h00_0340 && a < 24'h00_0350)
			return ADDR4[8*a[3:0] +: 8];
		return 8'hFF;
	endfunction

	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask

	// one host transfer; ok=0 means the memory refuses and the lines float high
	task automatic run(host_cmd_t c, logic q, logic [23:0] a, int n, logic ok);
		int k;
		for (k = 0; k < n; k++)
			exp_q.push_back(ok ? exp_byte(c, a + 24'(k)) : 8'hFF);
		k = 0;
		while (o_ready !== 1'b1 && k < 4000)
		begin
			@(negedge i_core_clk);
			k++;
		end
		if (k >= 4000)
		begin
			$display("MISMATCH host ready expected 1 seen timeout");
			error_cnt++;
			test_done();
		end
		i_cmd = c;
		i_quad = q;
		i_quad_mode = q;
		i_addr = a;
		i_rx_len = 8'(n);
		i_start = 1'b1;
		@(negedge i_core_clk);
		i_start = 1'b0;
		k = 0;
		while (o_done !== 1'b1 && k < 9000)
		begin
			@(negedge i_core_clk);
			k++;
		end
		if (k >= 9000)
		begin
			$display("MISMATCH transfer done expected 1 seen timeout");
			error_cnt++;
			test_done();
		end
	endtask

	task automatic sleep();
		i_sleep_req = 1'b1;
		@(negedge i_core_clk);
		i_sleep_req = 1'b0;
		repeat (3) @(negedge i_core_clk);
	endtask

	always @(negedge i_core_clk)
	begin
		if (o_rx_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				$display("MISMATCH rx byte expected none seen %h", o_rx_data);
				error_cnt++;
			end
			else
				check("rx byte", exp_q.pop_front(), o_rx_data);
		end
		if (o_cmd_ignored === 1'b1)
			ign_cnt++;
	end

	initial
	begin
		i_resetn = 1'b0;
		{i_busy, i_quad_mode, i_sleep_req, i_start, i_quad} = 5'h00;
		i_cmd = CMD_WAKE;
		i_addr = 24'h00_0000;
		i_rx_len = 8'h00;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_resetn = 1'b1;
		run(CMD_PARAM_READ, 1'b0, 24'h00_0000, 8, 1'b1);
		run(CMD_PARAM_READ, 1'b0, 24'h00_02FF, 2, 1'b1);
		run(CMD_PARAM_READ, 1'b1, 24'h00_033F, 3, 1'b1);
		run(CMD_PARAM_READ, 1'b1, 24'h00_034F, 2, 1'b1);
		$display("end of parameter space test");
		run(CMD_IDENTIFY, 1'b0, 24'h00_0000, 3, 1'b1);
		run(CMD_IDENTIFY, 1'b1, 24'h00_0000, 2, 1'b1);
		$display("end of identify test");
		sleep();
		check("asleep", 8'h01, {7'h00, o_deep_sleep});
		base = ign_cnt;
		run(CMD_PARAM_READ, 1'b0, 24'h00_0000, 2, 1'b0);
		check("ignored count", 8'h01, 8'(ign_cnt - base));
		run(CMD_WAKE, 1'b0, 24'h00_0000, 0, 1'b1);
		check("awake", 8'h00, {7'h00, o_deep_sleep});
		run(CMD_PARAM_READ, 1'b0, 24'h00_0000, 4, 1'b1);
		$display("end of deep sleep test");
		sleep();
		i_busy = 1'b1;
		base = ign_cnt;
		run(CMD_WAKE, 1'b1, 24'h00_0000, 0, 1'b1);
		check("busy ignored", 8'h01, 8'(ign_cnt - base));
		check("still asleep", 8'h01, {7'h00, o_deep_sleep});
		i_busy = 1'b0;
		run(CMD_WAKE, 1'b1, 24'h00_0000, 0, 1'b1);
		check("woken", 8'h00, {7'h00, o_deep_sleep});
		i_busy = 1'b1;
		run(CMD_PARAM_READ, 1'b0, 24'h00_0004, 3, 1'b1);
		i_busy = 1'b0;
		$display("end of busy test");
		repeat (6)
			run(CMD_PARAM_READ, 1'(xorshift() & 32'h0000_0001), 24'(xorshift() % 8),
				int'(xorshift() % 3) + 1, 1'b1);
		$display("end of random read test");
		repeat (4) @(negedge i_core_clk);
		check("bytes left", 8'h00, 8'(exp_q.size()));
		test_done();
	end
endmodule
`default_nettype wire
